// [dv/sasc_host_model.sv]
// Purpose: Serial host driving the converter link
// Assumes: 125 ns link clock, parked low between bursts
// Notes:   A released data line shows the inverse of its last bit
`timescale 1ns/1ps

// ============================================================
// Host model
module sasc_host_model (
    // Driven by the host
    output logic serial_clk,
    output logic chip_select_low,
    output logic serial_data_in,
    // Read by the host
    input wire logic serial_data_out
);
    // Idle: deselected, clock still
    initial begin
        serial_clk = 1'h0;
        chip_select_low = 1'h1;
        serial_data_in = 1'h0;
    end

    // Select edges kept clear of clock edges
    task automatic sel(input logic on);
        #40;
        chip_select_low = ~on;
        if (!on)
            serial_data_in = ~serial_data_in;
        #40;
    endtask : sel

    // Burst without pauses, so a conversion never waits on the host
    task automatic run(input int n, input logic [63:0] din, output logic [63:0] rx);
        rx = '0;
        for (int i = 0; i < n; i++) begin
            serial_data_in = din[i];
            #62.5;
            serial_clk = 1'h1;
            rx[i] = serial_data_out;
            #62.5;
            serial_clk = 1'h0;
        end
    endtask : run
endmodule : sasc_host_model

// [dv/sasc_serial_control_sva.sv]
// Purpose: Port checks for the serial converter control block
// Assumes: One clk_sys domain; link pins seen as async levels
// Notes:   Bound from the bench top file
`timescale 1ns/1ps

// ============================================================
// Checker
module sasc_serial_control_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link pins
    input wire logic chip_select_low,
    input wire logic serial_data_out_oe,
    input wire logic conversion_done_strobe,
    input wire logic conversion_done_strobe_oe,
    // Front end
    input wire logic hardware_shutdown_low,
    input wire logic [7:0] dac_code,
    input wire logic channel_sel_top,
    input wire logic channel_sel_mid,
    input wire logic channel_sel_low,
    input wire logic input_config_select,
    input wire logic polarity_coding_select,
    input wire logic track_enable,
    input wire logic power_down_full,
    input wire logic power_down_fast
);
    logic [7:0] trk_cnt_reg, trk_cnt_next, idl_cnt_reg, idl_cnt_next;
    logic [11:0] stb_cnt_reg, stb_cnt_next;
    logic [4:0] fields;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    assign fields = {channel_sel_top, channel_sel_mid, channel_sel_low, polarity_coding_select, input_config_select};

    // Run lengths; strobe count restarts at each track window; idle and strobe counts saturate, track count wraps
    always_comb begin
        trk_cnt_next = track_enable ? trk_cnt_reg + 8'h01 : 8'h00;
        idl_cnt_next = track_enable ? 8'h00 : idl_cnt_reg + {7'h00, ~&idl_cnt_reg};
        stb_cnt_next = (conversion_done_strobe || track_enable) ? 12'h000 : stb_cnt_reg + {11'h000, ~&stb_cnt_reg};
    end

    // Counter registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trk_cnt_reg <= 8'h00;
            idl_cnt_reg <= 8'h00;
            stb_cnt_reg <= 12'h000;
        end else begin
            trk_cnt_reg <= trk_cnt_next;
            idl_cnt_reg <= idl_cnt_next;
            stb_cnt_reg <= stb_cnt_next;
        end
    end

    a_oe_off_deselect: assert property (chip_select_low [*6] |-> !serial_data_out_oe)
        else $error("Output enable high while deselected");
    a_oe_pair_match: assert property (serial_data_out_oe == conversion_done_strobe_oe)
        else $error("Output enables disagree");
    a_track_length: assert property ($fell(track_enable) |-> trk_cnt_reg >= 8'h4a && trk_cnt_reg <= 8'h52)
        else $error("Track window not two and a half link clocks");
    a_sar_first_trial: assert property ($fell(track_enable) |-> ##[0:4] (dac_code == 8'h80 && !conversion_done_strobe))
        else $error("Conversion did not start at end of control byte");
    a_strobe_min_delay: assert property ($rose(conversion_done_strobe) |-> stb_cnt_reg >= 12'h370)
        else $error("Done strobe rose too early");
    a_fields_hold: assert property (idl_cnt_reg > 8'h20 |-> $stable(fields))
        else $error("Control fields changed between bytes");
    a_wake_clear: assert property (track_enable |-> !(power_down_full || power_down_fast))
        else $error("Power-down still set while tracking");
    a_shutdown_power: assert property (!hardware_shutdown_low [*4] |-> power_down_full)
        else $error("Shutdown pin did not force power-down");
endmodule : sasc_serial_control_sva

// [dv/test_sasc_serial_control.sv]
// Purpose: Self-checking bench for the serial converter control block
// Assumes: Comparator modelled as held input at or above trial code
// Notes:   Table rows for plain frames, hand tests for streams and reset
`timescale 1ns/1ps

// ============================================================
// Bench top
module test_sasc_serial_control import sasc_pkg::*;;
    typedef struct packed {logic [7:0] ctrl; logic [7:0] v; logic [3:0] lead; logic [7:0] res; logic [1:0] pd;} sasc_row_type;
    // Control byte, input, idle zeros ahead, result, {full, fast} power-down
    localparam sasc_row_type ROWS [6] = '{
        '{8'h8f, 8'ha5, 4'h0, 8'ha5, 2'h0},
        '{8'hf7, 8'ha5, 4'h3, 8'h25, 2'h0},
        '{8'hab, 8'hff, 4'h0, 8'hff, 2'h0},
        '{8'hd0, 8'h00, 4'h1, 8'h80, 2'h2},
        '{8'hbd, 8'h3c, 4'h0, 8'h3c, 2'h1},
        '{8'h9f, 8'h00, 4'h2, 8'h00, 2'h0}
    };
    localparam logic [7:0] STRM [3] = '{8'hcf, 8'he7, 8'h9b};
    localparam int SPACE [2] = '{16, 11};
    logic clk_sys;
    logic rst_n;
    logic hardware_shutdown_low;
    logic sdo_line;
    logic [7:0] vin = 8'h00;
    logic serial_clk, chip_select_low, serial_data_in, serial_data_out, serial_data_out_oe, comparator_in;
    logic conversion_done_strobe, conversion_done_strobe_oe, channel_sel_top, channel_sel_mid, channel_sel_low;
    logic input_config_select, polarity_coding_select, track_enable, power_down_full, power_down_fast;
    logic [7:0] dac_code;
    logic [63:0] rx, d;
    int err_total = 0;
    int n_checks = 0;
    int b;

    always #2 clk_sys = ~clk_sys;
    // Comparator follows the trial code at once
    assign comparator_in = (vin >= dac_code);
    // Released output reads as the inverse of its last bit
    assign sdo_line = serial_data_out_oe ? serial_data_out : ~serial_data_out;

    sasc_serial_control u_sasc_serial_control (.clk_sys, .rst_n, .serial_clk, .chip_select_low, .serial_data_in,
        .serial_data_out, .serial_data_out_oe, .conversion_done_strobe, .conversion_done_strobe_oe, .comparator_in,
        .hardware_shutdown_low, .dac_code, .channel_sel_top, .channel_sel_mid, .channel_sel_low, .input_config_select,
        .polarity_coding_select, .track_enable, .power_down_full, .power_down_fast);
    sasc_host_model u_sasc_host_model (.serial_clk, .chip_select_low, .serial_data_in, .serial_data_out(sdo_line));

    // ============================================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // Byte placed MSB first from clock index at
    task automatic put(input logic [7:0] c, input int at, inout logic [63:0] v);
        for (int i = 0; i < 8; i++)
            v[at + i] = c[7 - i];
    endtask : put
    function automatic logic [7:0] pick(input logic [63:0] v, input int at);
        for (int j = 0; j < 8; j++)
            pick[7 - j] = v[at + j];
    endfunction : pick
    task automatic fields(input logic [7:0] c);
        chk({3'h0, channel_sel_top, channel_sel_mid, channel_sel_low, polarity_coding_select, input_config_select},
            {3'h0, c[6:2]}, "fields");
    endtask : fields
    task automatic do_reset();
        rst_n = 1'h0;
        cyc(12);
        chk(dac_code, 8'h00, "reset code");
        chk({3'h0, track_enable, power_down_full, power_down_fast, conversion_done_strobe, serial_data_out_oe},
            8'h00, "reset flags");
        rst_n = 1'h1;
        cyc(6);
    endtask : do_reset
    task automatic results();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // ============================================================
    // Main sequence
    initial begin
        clk_sys = 1'h0;
        hardware_shutdown_low = 1'h1;
        do_reset();
        // Plain 24-clock frames, one per row
        foreach (ROWS[k]) begin
            vin = ROWS[k].v;
            b = int'(ROWS[k].lead);
            d = '0;
            put(ROWS[k].ctrl, b, d);
            u_sasc_host_model.sel(1'h1);
            u_sasc_host_model.run(24 + b, d, rx);
            u_sasc_host_model.sel(1'h0);
            cyc(10);
            chk({7'h00, rx[b + 9]}, 8'h00, "busy bit");
            chk(pick(rx, b + 10), ROWS[k].res, "result");
            chk({2'h0, rx[b + 18 +: 6]}, 8'h00, "trailing zeros");
            chk({6'h00, power_down_full, power_down_fast}, {6'h00, ROWS[k].pd}, "power mode");
            fields(ROWS[k].ctrl);
        end
        // Back-to-back bytes, each readout but the last overlapping the next byte
        foreach (SPACE[s]) begin
            vin = 8'h6d;
            d = '0;
            for (int m = 0; m < 3; m++)
                put(STRM[m], m * SPACE[s], d);
            u_sasc_host_model.sel(1'h1);
            u_sasc_host_model.run(2 * SPACE[s] + 18, d, rx);
            u_sasc_host_model.sel(1'h0);
            cyc(10);
            for (int m = 0; m < 3; m++)
                chk(pick(rx, m * SPACE[s] + 10), STRM[m][3] ? vin : vin ^ 8'h80, "stream");
            fields(STRM[2]);
        end
        // Internal clock, deselected while converting
        vin = 8'hc3;
        d = '0;
        put(8'hae, 0, d);
        u_sasc_host_model.sel(1'h1);
        u_sasc_host_model.run(8, d, rx);
        u_sasc_host_model.sel(1'h0);
        cyc(20);
        chk({6'h00, serial_data_out_oe, conversion_done_strobe}, 8'h00, "deselected busy");
        for (int w = 0; w < 2000 && conversion_done_strobe !== 1'h1; w++)
            cyc(1);
        chk({7'h00, conversion_done_strobe}, 8'h01, "done strobe");
        u_sasc_host_model.sel(1'h1);
        cyc(10);
        chk({7'h00, serial_data_out_oe}, 8'h01, "enabled");
        u_sasc_host_model.run(9, '0, rx);
        u_sasc_host_model.sel(1'h0);
        chk(pick(rx, 1), vin, "internal result");
        // Reset in mid-conversion
        u_sasc_host_model.sel(1'h1);
        u_sasc_host_model.run(8, d, rx);
        u_sasc_host_model.sel(1'h0);
        cyc(100);
        do_reset();
        // Shutdown pin
        hardware_shutdown_low = 1'h0;
        cyc(8);
        chk({7'h00, power_down_full}, 8'h01, "shutdown");
        hardware_shutdown_low = 1'h1;
        cyc(4);
        results();
    end

    // Watchdog, well past the expected 40 us of traffic
    initial begin
        #200000;
        err_total++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        results();
    end
endmodule : test_sasc_serial_control

bind sasc_serial_control sasc_serial_control_sva u_sasc_serial_control_sva (.clk_sys, .rst_n, .chip_select_low,
    .serial_data_out_oe, .conversion_done_strobe, .conversion_done_strobe_oe, .hardware_shutdown_low, .dac_code,
    .channel_sel_top, .channel_sel_mid, .channel_sel_low, .input_config_select, .polarity_coding_select,
    .track_enable, .power_down_full, .power_down_fast);

// [rtl/sasc_pkg.sv]
// Purpose: Shared constants for the serial converter control block
// Assumes: 250 MHz system clock, 8-bit successive approximation
// Notes:   Control byte layout, mode codes, step counts and oscillator timing

// ============================================================
// Package
package sasc_pkg;

    // Control byte field positions
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_CHAN_HI = 6;
    localparam int CTRL_CHAN_LO = 4;
    localparam int CTRL_POLARITY_BIT = 3;
    localparam int CTRL_CONFIG_BIT = 2;
    localparam int CTRL_MODE_HI = 1;
    localparam int CTRL_MODE_LO = 0;

    // Mode field codes
    localparam logic [1:0] MODE_FULL_PD = 2'h0;
    localparam logic [1:0] MODE_FAST_PD = 2'h1;
    localparam logic [1:0] MODE_INT_CLK = 2'h2;
    localparam logic [1:0] MODE_EXT_CLK = 2'h3;

    // Receive bit counter marks, counted after the start bit
    localparam logic [2:0] RX_ACQ_CNT = 3'h4;
    localparam logic [2:0] RX_LAST_CNT = 3'h6;

    // Conversion steps and readout
    localparam int RESULT_BITS = 8;
    localparam logic [4:0] CONV_STEPS = 5'h0c;
    localparam logic [4:0] EXT_LAST_STEP = 5'h10;
    localparam logic [3:0] READ_LAST = 4'h9;
    localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

    // Internal conversion oscillator
    localparam longint SYS_CLK_HZ = 250000000;
    localparam longint OSC_HZ = 3300000;
    localparam int OSC_TICK_CYCLES = int'(SYS_CLK_HZ / OSC_HZ);

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = MODE_EXT_CLK;

endpackage : sasc_pkg

// [rtl/sasc_serial_control.sv]
// Purpose: Serial control and readout of an 8-bit SAR converter
// Assumes: serial_clk idles between frames; SAR comparator is an async level
// Notes:   Link side receives on serial_clk; conversion and output run on clk_sys

`timescale 1ns/1ps

module sasc_serial_control import sasc_pkg::*; (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial link
    input wire logic serial_clk,
    input wire logic chip_select_low,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic conversion_done_strobe,
    output logic conversion_done_strobe_oe,
    // Analog front end
    input wire logic comparator_in,
    input wire logic hardware_shutdown_low,
    output logic [7:0] dac_code,
    output logic channel_sel_top,
    output logic channel_sel_mid,
    output logic channel_sel_low,
    output logic input_config_select,
    output logic polarity_coding_select,
    output logic track_enable,
    output logic power_down_full,
    output logic power_down_fast
);

    // ============================================================
    // Link domain: control byte receiver
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CONV_EXT = 4'h2,
        ST_CONV_INT = 4'h4,
        ST_READ = 4'h8
    } sasc_state_type;

    logic rx_clear_n;
    logic rx_started_reg, rx_started_next;
    logic [2:0] rx_cnt_reg, rx_cnt_next;
    logic [5:0] rx_shift_reg, rx_shift_next;
    logic [7:0] ctrl_word_reg, ctrl_word_next;
    logic byte_tgl_reg, byte_tgl_next;
    logic start_tgl_reg, start_tgl_next;
    logic acq_tgl_reg, acq_tgl_next;
    logic fall_tgl_reg, fall_tgl_next;

    // Deselect clears the frame state, since serial_clk stops outside frames
    assign rx_clear_n = rst_n & ~chip_select_low;

    // Next receive state on each rising edge
    always_comb begin
        rx_started_next = rx_started_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_shift_next = rx_shift_reg;
        ctrl_word_next = ctrl_word_reg;
        byte_tgl_next = byte_tgl_reg;
        start_tgl_next = start_tgl_reg;
        acq_tgl_next = acq_tgl_reg;
        if (!rx_started_reg) begin
            if (serial_data_in) begin
                rx_started_next = 1'b1;
                rx_cnt_next = 3'h0;
                start_tgl_next = ~start_tgl_reg;
            end
        end else begin
            rx_shift_next = {rx_shift_reg[4:0], serial_data_in};
            rx_cnt_next = rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == RX_ACQ_CNT) begin
                acq_tgl_next = ~acq_tgl_reg;
            end
            if (rx_cnt_reg == RX_LAST_CNT) begin
                // Word stays put until the next byte, so clk_sys may read it
                ctrl_word_next = {1'b1, rx_shift_reg, serial_data_in};
                byte_tgl_next = ~byte_tgl_reg;
                rx_started_next = 1'b0;
            end
        end
    end

    // Frame state, cleared by deselect
    always_ff @(posedge serial_clk or negedge rx_clear_n) begin
        if (!rx_clear_n) begin
            rx_started_reg <= 1'b0;
            rx_cnt_reg <= 3'h0;
            rx_shift_reg <= 6'h00;
        end else begin
            rx_started_reg <= rx_started_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_shift_reg <= rx_shift_next;
        end
    end

    // Event toggles and control word survive deselect
    always_ff @(posedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_word_reg <= CTRL_RESET;
            byte_tgl_reg <= 1'b0;
            start_tgl_reg <= 1'b0;
            acq_tgl_reg <= 1'b0;
        end else begin
            ctrl_word_reg <= ctrl_word_next;
            byte_tgl_reg <= byte_tgl_next;
            start_tgl_reg <= start_tgl_next;
            acq_tgl_reg <= acq_tgl_next;
        end
    end

    // Falling-edge event toggle
    always_comb begin
        fall_tgl_next = ~fall_tgl_reg;
    end

    always_ff @(negedge serial_clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_tgl_reg <= 1'b0;
        end else begin
            fall_tgl_reg <= fall_tgl_next;
        end
    end

    // ============================================================
    // Crossing into clk_sys
    logic [6:0] sync_vec;
    logic [3:0] tgl_prev_reg, tgl_prev_next;
    logic ev_byte, ev_start, ev_acq, ev_fall;
    logic cs_active, comp_level, shutdown_active;

    sasc_sync2 #(
        .W(7)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in({comparator_in, ~hardware_shutdown_low, ~chip_select_low, // Inverted: reset flop reads idle
                   fall_tgl_reg, acq_tgl_reg, start_tgl_reg, byte_tgl_reg}),
        .sync_out(sync_vec)
    );

    // Edge detect on synchronised toggles
    always_comb begin
        tgl_prev_next = sync_vec[3:0];
        ev_byte = sync_vec[0] ^ tgl_prev_reg[0];
        ev_start = sync_vec[1] ^ tgl_prev_reg[1];
        ev_acq = sync_vec[2] ^ tgl_prev_reg[2];
        ev_fall = sync_vec[3] ^ tgl_prev_reg[3];
        cs_active = sync_vec[4];
        shutdown_active = sync_vec[5];
        comp_level = sync_vec[6];
    end

    always_ff @(posedge clk_sys) begin
        tgl_prev_reg <= tgl_prev_next;
    end

    // ============================================================
    // Conversion and readout
    sasc_state_type state_reg, state_next;
    logic armed_reg, armed_next;
    logic track_reg, track_next;
    logic [4:0] step_reg, step_next;
    logic [7:0] mask_reg, mask_next;
    logic [7:0] trial_reg, trial_next;
    logic [7:0] result_reg, result_next;
    logic [3:0] read_cnt_reg, read_cnt_next;
    logic [6:0] osc_cnt_reg, osc_cnt_next;
    logic [2:0] chan_reg, chan_next;
    logic unipolar_reg, unipolar_next;
    logic single_reg, single_next;
    logic [1:0] mode_reg, mode_next;
    logic sdo_reg, sdo_next;
    logic sdo_oe_reg, sdo_oe_next;
    logic strobe_reg, strobe_next;
    logic strobe_oe_reg, strobe_oe_next;
    logic pd_full_reg, pd_full_next;
    logic pd_fast_reg, pd_fast_next;
    logic osc_tick;

    // Bipolar flips the MSB of the offset-binary SAR word
    function automatic logic [7:0] code_word(input logic [7:0] w, input logic uni);
        code_word = uni ? w : {~w[7], w[6:0]};
    endfunction : code_word

    // Bit n (1..8) of a word, MSB first; zero outside that range
    function automatic logic pick_bit(input logic [7:0] w, input logic [4:0] n);
        pick_bit = 1'b0;
        if (n >= 5'h01 && n <= 5'h08) begin
            pick_bit = w[3'(5'h08 - n)];
        end
    endfunction : pick_bit

    // One SAR decision: keep or drop the trial bit, then try the next
    function automatic logic [7:0] sar_step(input logic [7:0] t, input logic [7:0] m, input logic c);
        sar_step = (c ? t : (t & ~m)) | (m >> 1);
    endfunction : sar_step

    always_comb begin
        state_next = state_reg;
        armed_next = armed_reg;
        track_next = track_reg;
        step_next = step_reg;
        mask_next = mask_reg;
        trial_next = trial_reg;
        result_next = result_reg;
        read_cnt_next = read_cnt_reg;
        chan_next = chan_reg;
        unipolar_next = unipolar_reg;
        single_next = single_reg;
        mode_next = mode_reg;
        sdo_next = sdo_reg;
        strobe_next = strobe_reg;
        pd_full_next = pd_full_reg;
        pd_fast_next = pd_fast_reg;
        osc_tick = (osc_cnt_reg == 7'(OSC_TICK_CYCLES - 1));
        osc_cnt_next = 7'h00;
        // Output drivers follow select; conversion itself ignores it
        sdo_oe_next = cs_active;
        strobe_oe_next = cs_active;

        // Wake first so that a completion in the same cycle still sleeps
        if (ev_start) begin
            pd_full_next = 1'b0;
            pd_fast_next = 1'b0;
        end
        if (ev_acq) begin
            track_next = 1'b1;
        end
        if (ev_byte) begin
            chan_next = ctrl_word_reg[CTRL_CHAN_HI:CTRL_CHAN_LO];
            unipolar_next = ctrl_word_reg[CTRL_POLARITY_BIT];
            single_next = ctrl_word_reg[CTRL_CONFIG_BIT];
            mode_next = ctrl_word_reg[CTRL_MODE_HI:CTRL_MODE_LO];
            armed_next = 1'b1;
        end

        case (state_reg)
            ST_IDLE: begin
                sdo_next = 1'b0;
            end
            ST_CONV_EXT: begin
                if (ev_fall) begin
                    step_next = step_reg + 5'h01;
                    if (mask_reg != 8'h00) begin
                        trial_next = sar_step(trial_reg, mask_reg, comp_level);
                        mask_next = mask_reg >> 1;
                    end
                    // One busy cycle, eight result bits, then zeros
                    sdo_next = pick_bit(code_word(trial_reg, unipolar_reg), step_next - 5'h01);
                    if (step_next == CONV_STEPS) begin
                        pd_full_next = (mode_reg == MODE_FULL_PD);
                        pd_fast_next = (mode_reg == MODE_FAST_PD);
                    end
                    if (step_next == EXT_LAST_STEP) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_CONV_INT: begin
                sdo_next = 1'b0;
                strobe_next = 1'b0;
                osc_cnt_next = osc_tick ? 7'h00 : osc_cnt_reg + 7'h01;
                if (osc_tick) begin
                    step_next = step_reg + 5'h01;
                    if (mask_reg != 8'h00) begin
                        trial_next = sar_step(trial_reg, mask_reg, comp_level);
                        mask_next = mask_reg >> 1;
                    end
                    if (step_next == CONV_STEPS) begin
                        result_next = code_word(trial_reg, unipolar_reg);
                        strobe_next = 1'b1;
                        read_cnt_next = 4'h0;
                        state_next = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (ev_fall) begin
                    if (read_cnt_reg != READ_LAST) begin
                        read_cnt_next = read_cnt_reg + 4'h1;
                    end
                    sdo_next = pick_bit(result_reg, {1'b0, read_cnt_reg + 4'h1});
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase

        // Arrival of a new byte restarts at its eighth falling edge
        if (armed_reg && ev_fall) begin
            state_next = (mode_reg == MODE_INT_CLK) ? ST_CONV_INT : ST_CONV_EXT;
            step_next = 5'h00;
            mask_next = SAR_FIRST_TRIAL;
            trial_next = SAR_FIRST_TRIAL;
            track_next = 1'b0;
            armed_next = 1'b0;
            strobe_next = 1'b0;
            sdo_next = 1'b0;
        end

        // Hardware shutdown overrides state, arming, tracking, full power-down and data out
        if (shutdown_active) begin
            state_next = ST_IDLE;
            armed_next = 1'b0;
            track_next = 1'b0;
            pd_full_next = 1'b1;
            sdo_next = 1'b0;
        end
    end

    // Conversion state registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            armed_reg <= 1'b0;
            track_reg <= 1'b0;
            step_reg <= 5'h00;
            mask_reg <= 8'h00;
            trial_reg <= 8'h00;
            result_reg <= 8'h00;
            read_cnt_reg <= 4'h0;
            osc_cnt_reg <= 7'h00;
            chan_reg <= 3'h0;
            unipolar_reg <= 1'b0;
            single_reg <= 1'b0;
            mode_reg <= MODE_RESET;
            sdo_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
            strobe_reg <= 1'b0;
            strobe_oe_reg <= 1'b0;
            pd_full_reg <= 1'b0;
            pd_fast_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            armed_reg <= armed_next;
            track_reg <= track_next;
            step_reg <= step_next;
            mask_reg <= mask_next;
            trial_reg <= trial_next;
            result_reg <= result_next;
            read_cnt_reg <= read_cnt_next;
            osc_cnt_reg <= osc_cnt_next;
            chan_reg <= chan_next;
            unipolar_reg <= unipolar_next;
            single_reg <= single_next;
            mode_reg <= mode_next;
            sdo_reg <= sdo_next;
            sdo_oe_reg <= sdo_oe_next;
            strobe_reg <= strobe_next;
            strobe_oe_reg <= strobe_oe_next;
            pd_full_reg <= pd_full_next;
            pd_fast_reg <= pd_fast_next;
        end
    end

    // ============================================================
    // Outputs, all straight from flops
    assign serial_data_out = sdo_reg;
    assign serial_data_out_oe = sdo_oe_reg;
    assign conversion_done_strobe = strobe_reg;
    assign conversion_done_strobe_oe = strobe_oe_reg;
    assign dac_code = trial_reg;
    assign channel_sel_top = chan_reg[2];
    assign channel_sel_mid = chan_reg[1];
    assign channel_sel_low = chan_reg[0];
    assign input_config_select = single_reg;
    assign polarity_coding_select = unipolar_reg;
    assign track_enable = track_reg;
    assign power_down_full = pd_full_reg;
    assign power_down_fast = pd_fast_reg;

endmodule : sasc_serial_control

// [rtl/sasc_sync2.sv]
// Purpose: Two-flop synchroniser, one lane per bit
// Assumes: Inputs are levels or toggles from another clock domain
// Notes:   First stage feeds only the second stage

`timescale 1ns/1ps

// ============================================================
// Synchroniser
module sasc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_next;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            // Per-lane next values
            always_comb begin
                meta_next[i] = rst_n ? async_in[i] : 1'b0;
                sync_next[i] = rst_n ? meta_reg[i] : 1'b0;
            end
        end
    endgenerate

    // Both stages register together
    always_ff @(posedge clk_sys) begin
        meta_reg <= meta_next;
        sync_out <= sync_next;
    end

endmodule : sasc_sync2
